// File: rtl/lpm_pkg.sv
`default_nettype none
package lpm_pkg;
	// Timing
	localparam int unsigned CLK_FREQ_HZ     = 10_000_000;
	localparam int unsigned LPO_FREQ_HZ     = 1_000;
	localparam int unsigned LPO_CYCLES      = CLK_FREQ_HZ / LPO_FREQ_HZ;
	localparam int unsigned LPO_CNT_W       = 14;
	localparam int unsigned WTMR_CNT_W      = 11;
	localparam int unsigned WTMR_BASE_LOG2  = 3;

	// Widths
	localparam int unsigned PIN_W           = 8;
	localparam int unsigned ADDR_W          = 5;
	localparam int unsigned DATA_W          = 32;
	localparam int unsigned REG_W           = 8;
	localparam int unsigned SEL_W           = 3;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL      = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS    = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_PWR_ACK   = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_PORT_DATA = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_PORT_DIR  = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_PERIPH_EN = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_OSC_TRIM  = 5'h18;

	// Control fields
	localparam int unsigned CTRL_SEL_LSB    = 0;
	localparam int unsigned CTRL_DEEP_BIT   = 3;
	localparam int unsigned CTRL_LVDET_BIT  = 4;
	localparam int unsigned CTRL_LVSTOP_BIT = 5;
	localparam int unsigned CTRL_IRQPOL_BIT = 6;
	localparam int unsigned ACK_BIT         = 0;

	// Status fields
	localparam int unsigned STAT_MODE_LSB   = 0;
	localparam int unsigned STAT_PPD_BIT    = 2;
	localparam int unsigned STAT_LATCH_BIT  = 3;
	localparam int unsigned STAT_BKGD_BIT   = 4;
	localparam int unsigned STAT_WAKE_LSB   = 5;

	// Reset values
	localparam logic [REG_W-1:0] CTRL_RST      = 8'h00;
	localparam logic [REG_W-1:0] PORT_DATA_RST = 8'h00;
	localparam logic [REG_W-1:0] PORT_DIR_RST  = 8'h00;
	localparam logic [REG_W-1:0] PERIPH_EN_RST = 8'h00;
	localparam logic [REG_W-1:0] OSC_TRIM_RST  = 8'h80;

	// Debug commands
	localparam logic [1:0] DBG_CMD_HALT     = 2'h0;
	localparam logic [1:0] DBG_CMD_MEM_STAT = 2'h1;

	typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_SHALLOW, MODE_DEEP} lpm_mode_e;
	typedef enum logic [2:0] {VEC_RESET, VEC_STACK, VEC_IRQ, VEC_KEYPAD, VEC_WTMR} lpm_vec_e;
endpackage
`default_nettype wire

// File: rtl/lpm_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - Mode pin high at reset release gives run mode and a reset vector fetch.
// RULE2 - Wait instruction stops CPU clock and clears the interrupt mask bit.
// RULE3 - Any interrupt in wait resumes CPU through the stacking sequence.
// RULE4 - In wait only halt and status debug commands run; status reports error.
// RULE5 - Debug halt during wait wakes into active background mode.
// RULE6 - Deep stop allowed only if low voltage detection is off for stop.
// RULE7 - Deep stop powers off all regulated logic except RAM; regulator, converter standby.
// RULE8 - Deep stop entry latches all pins until acknowledge bit is written one.
// RULE9 - Deep stop ends on reset pin, active-low IRQ or periodic wakeup.
// RULE10 - Deep stop wake restarts as power-on reset; pins remain latched.
// RULE11 - Partial powerdown flag set after deep wake until acknowledge is written.
// RULE12 - Unrestored port registers drive their reset values when latches open.
// RULE13 - Pins of unenabled peripherals fall to port control when latches open.
// RULE14 - 1 kHz source drives periodic wakeup; select zero disables source and wakeup.
// RULE15 - Shallow stop halts clocks, generator, converter; regulator standby; state kept.
// RULE16 - Shallow stop keeps pins through retained logic, not pad latches.
// RULE17 - Shallow stop ends on reset, IRQ, keypad or wakeup timer with matching vector.
// RULE18 - Software never selects full powerdown stop; pins must hold.
// RULE19 - Stop instruction turns clock generator off with its output held static.
// RULE20 - Oscillator trim settings survive shallow stop for fast relock.
// RULE21 - Wake sources are synchronised before any vector fetch is issued.
module lpm_mode_ctrl #(
	parameter int unsigned LPO_CYCLES = lpm_pkg::LPO_CYCLES
) (
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        avs_read_i,
	input  wire logic                        avs_write_i,
	input  wire logic [lpm_pkg::ADDR_W-1:0]  avs_address_i,
	input  wire logic [lpm_pkg::DATA_W-1:0]  avs_writedata_i,
	input  wire logic [3:0]                  avs_byteenable_i,
	output logic      [lpm_pkg::DATA_W-1:0]  avs_readdata_o,
	output logic                             avs_waitrequest_o,
	input  wire logic                        background_mode_select_pin_i,
	input  wire logic                        reset_pin_n_i,
	input  wire logic                        irq_pin_i,
	input  wire logic [lpm_pkg::PIN_W-1:0]   keypad_pins_i,
	input  wire logic                        irq_req_i,
	input  wire logic                        wait_exec_i,
	input  wire logic                        stop_exec_i,
	input  wire logic                        dbg_valid_i,
	input  wire logic [1:0]                  dbg_cmd_i,
	input  wire logic [lpm_pkg::PIN_W-1:0]   periph_out_i,
	input  wire logic [lpm_pkg::PIN_W-1:0]   periph_oe_i,
	output logic      [lpm_pkg::PIN_W-1:0]   pad_out_o,
	output logic      [lpm_pkg::PIN_W-1:0]   pad_oe_o,
	output logic                             pins_latched_o,
	output logic [1:0]                       mode_o,
	output logic                             cpu_clk_en_o,
	output logic                             cond_code_mask_clr_o,
	output logic                             vec_req_o,
	output logic [2:0]                       vec_kind_o,
	output logic                             sys_reset_o,
	output logic                             background_active_o,
	output logic                             dbg_ack_o,
	output logic                             dbg_err_o,
	output logic                             dbg_reject_o,
	output logic                             dbg_mem_go_o,
	output logic                             core_power_off_o,
	output logic                             regulator_standby_o,
	output logic                             converter_standby_o,
	output logic                             converter_disable_o,
	output logic                             gen_off_o,
	output logic                             gen_clk_static_o,
	output logic                             osc_halt_o,
	output logic                             lpo_en_o,
	output logic [lpm_pkg::REG_W-1:0]        osc_trim_o
);
	localparam logic [lpm_pkg::LPO_CNT_W-1:0] LPO_LAST = lpm_pkg::LPO_CNT_W'(LPO_CYCLES - 1);

	logic                           rst_meta_q;
	logic                           rst_sync_q;
	logic                           rst_n;
	logic                           irq_meta_q;
	logic                           irq_sync_q;
	logic [lpm_pkg::PIN_W-1:0]      keypad_meta_q;
	logic [lpm_pkg::PIN_W-1:0]      keypad_sync_q;
	logic                           rpin_meta_q;
	logic                           rpin_sync_q;
	lpm_pkg::lpm_mode_e             mode_q;
	lpm_pkg::lpm_mode_e             mode_d;
	logic [lpm_pkg::REG_W-1:0]      ctrl_q;
	logic [lpm_pkg::REG_W-1:0]      port_data_q;
	logic [lpm_pkg::REG_W-1:0]      port_dir_q;
	logic [lpm_pkg::REG_W-1:0]      periph_en_q;
	logic [lpm_pkg::REG_W-1:0]      osc_trim_q;
	logic                           partial_powerdown_flag_q;
	logic                           latched_q;
	logic                           boot_pending_q;
	logic [2:0]                     wake_src_q;
	logic [lpm_pkg::LPO_CNT_W-1:0]  lpo_cnt_q;
	logic [lpm_pkg::WTMR_CNT_W-1:0] wtmr_cnt_q;
	logic                           wtmr_tick_q;
	logic                           wait_q;
	logic [lpm_pkg::DATA_W-1:0]     rdata_q;
	logic [lpm_pkg::SEL_W-1:0]      wake_sel;
	logic                           lpo_en;
	logic                           irq_act;
	logic                           keypad_act;
	logic                           pin_rst_act;
	logic                           deep_wake;
	logic                           sys_clr;
	logic                           deep_ok;
	logic                           wait_int;
	logic                           dbg_halt;
	logic                           wr_go;
	logic                           ack_wr;
	logic                           enter_deep;

	function automatic logic [lpm_pkg::WTMR_CNT_W-1:0] wtmr_last(
		input logic [lpm_pkg::SEL_W-1:0] sel
	);
		logic [lpm_pkg::WTMR_CNT_W-1:0] one;
		one = lpm_pkg::WTMR_CNT_W'(1);
		return (one << (32'(sel) + lpm_pkg::WTMR_BASE_LOG2)) - one;
	endfunction

	function automatic logic wr_hit(
		input logic [lpm_pkg::ADDR_W-1:0] addr,
		input logic [lpm_pkg::ADDR_W-1:0] off,
		input logic                       go
	);
		return go && (addr == off);
	endfunction

	// Reset release through two flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	// Wake pins come from an unclocked world in stop; only the second stage is used
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_meta_q    <= 1'b1;
			irq_sync_q    <= 1'b1;
			keypad_meta_q <= '0;
			keypad_sync_q <= '0;
			rpin_meta_q   <= 1'b1;
			rpin_sync_q   <= 1'b1;
		end else begin
			irq_meta_q    <= irq_pin_i; // see RULE21
			irq_sync_q    <= irq_meta_q;
			keypad_meta_q <= keypad_pins_i;
			keypad_sync_q <= keypad_meta_q;
			rpin_meta_q   <= reset_pin_n_i;
			rpin_sync_q   <= rpin_meta_q;
		end
	end

	assign wake_sel    = ctrl_q[lpm_pkg::CTRL_SEL_LSB +: lpm_pkg::SEL_W];
	assign lpo_en      = (wake_sel != '0); // see RULE14
	assign pin_rst_act = !rpin_sync_q;
	assign keypad_act  = |keypad_sync_q;
	// Deep stop forces IRQ active low whatever polarity was programmed
	assign irq_act     = (mode_q == lpm_pkg::MODE_DEEP) ? !irq_sync_q : // see RULE9
		(ctrl_q[lpm_pkg::CTRL_IRQPOL_BIT] ? irq_sync_q : !irq_sync_q);
	assign deep_wake   = (mode_q == lpm_pkg::MODE_DEEP) &&
		(pin_rst_act || irq_act || wtmr_tick_q); // see RULE9
	assign sys_clr     = pin_rst_act || deep_wake; // see RULE10
	assign deep_ok     = !(ctrl_q[lpm_pkg::CTRL_LVDET_BIT] &&
		ctrl_q[lpm_pkg::CTRL_LVSTOP_BIT]); // see RULE6
	assign wait_int    = irq_req_i || irq_act || keypad_act || wtmr_tick_q; // see RULE3
	assign dbg_halt    = dbg_valid_i && (dbg_cmd_i == lpm_pkg::DBG_CMD_HALT);
	assign enter_deep  = (mode_q != lpm_pkg::MODE_DEEP) && (mode_d == lpm_pkg::MODE_DEEP);

	// Deep stop refused by the detector setting falls back to shallow stop
	always_comb begin
		mode_d = mode_q;
		if (sys_clr) begin
			mode_d = lpm_pkg::MODE_RUN;
		end else begin
			unique case (mode_q)
				lpm_pkg::MODE_RUN: begin
					if (wait_exec_i) begin
						mode_d = lpm_pkg::MODE_WAIT;
					end else if (stop_exec_i) begin
						mode_d = (ctrl_q[lpm_pkg::CTRL_DEEP_BIT] && deep_ok) ? // see RULE6
							lpm_pkg::MODE_DEEP : lpm_pkg::MODE_SHALLOW;
					end
				end
				lpm_pkg::MODE_WAIT: begin
					if (dbg_halt || wait_int) begin // see RULE5
						mode_d = lpm_pkg::MODE_RUN;
					end
				end
				lpm_pkg::MODE_SHALLOW: begin
					if (irq_act || keypad_act || wtmr_tick_q) begin // see RULE17
						mode_d = lpm_pkg::MODE_RUN;
					end
				end
				lpm_pkg::MODE_DEEP: begin
					mode_d = lpm_pkg::MODE_DEEP;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= lpm_pkg::MODE_RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Power and clock controls follow the next mode so they switch with it
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_o              <= lpm_pkg::MODE_RUN;
			cpu_clk_en_o        <= 1'b1;
			core_power_off_o    <= 1'b0;
			regulator_standby_o <= 1'b0;
			converter_standby_o <= 1'b0;
			converter_disable_o <= 1'b0;
			gen_off_o           <= 1'b0;
			gen_clk_static_o    <= 1'b0;
			osc_halt_o          <= 1'b0;
		end else begin
			mode_o              <= mode_d;
			cpu_clk_en_o        <= (mode_d == lpm_pkg::MODE_RUN); // see RULE2
			core_power_off_o    <= (mode_d == lpm_pkg::MODE_DEEP); // see RULE7
			regulator_standby_o <= (mode_d == lpm_pkg::MODE_DEEP) ||
				(mode_d == lpm_pkg::MODE_SHALLOW); // see RULE7 see RULE15
			converter_standby_o <= (mode_d == lpm_pkg::MODE_DEEP); // see RULE7
			converter_disable_o <= (mode_d == lpm_pkg::MODE_SHALLOW); // see RULE15
			gen_off_o           <= (mode_d == lpm_pkg::MODE_DEEP) ||
				(mode_d == lpm_pkg::MODE_SHALLOW); // see RULE19
			gen_clk_static_o    <= (mode_d == lpm_pkg::MODE_DEEP) ||
				(mode_d == lpm_pkg::MODE_SHALLOW); // see RULE19
			osc_halt_o          <= (mode_d == lpm_pkg::MODE_DEEP) ||
				(mode_d == lpm_pkg::MODE_SHALLOW); // see RULE15
		end
	end

	// CPU side events: mask clear, vectors, system reset, background entry
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cond_code_mask_clr_o <= 1'b0;
			vec_req_o            <= 1'b0;
			vec_kind_o           <= lpm_pkg::VEC_RESET;
			sys_reset_o          <= 1'b0;
			background_active_o  <= 1'b0;
			boot_pending_q       <= 1'b1;
		end else begin
			cond_code_mask_clr_o <= 1'b0;
			vec_req_o            <= 1'b0;
			sys_reset_o          <= sys_clr; // see RULE10
			if (sys_clr) begin
				boot_pending_q      <= 1'b1;
				background_active_o <= 1'b0;
			end else if (boot_pending_q) begin
				boot_pending_q <= 1'b0;
				if (background_mode_select_pin_i) begin
					vec_req_o  <= 1'b1; // see RULE1
					vec_kind_o <= lpm_pkg::VEC_RESET;
				end else begin
					background_active_o <= 1'b1;
				end
			end else begin
				unique case (mode_q)
					lpm_pkg::MODE_RUN: begin
						if (wait_exec_i) begin
							cond_code_mask_clr_o <= 1'b1; // see RULE2
						end
						if (dbg_halt) begin
							background_active_o <= 1'b1;
						end
					end
					lpm_pkg::MODE_WAIT: begin
						if (dbg_halt) begin
							background_active_o <= 1'b1; // see RULE5
						end else if (wait_int) begin
							vec_req_o  <= 1'b1; // see RULE3
							vec_kind_o <= lpm_pkg::VEC_STACK;
						end
					end
					lpm_pkg::MODE_SHALLOW: begin
						if (irq_act) begin
							vec_req_o  <= 1'b1; // see RULE17
							vec_kind_o <= lpm_pkg::VEC_IRQ;
						end else if (keypad_act) begin
							vec_req_o  <= 1'b1;
							vec_kind_o <= lpm_pkg::VEC_KEYPAD;
						end else if (wtmr_tick_q) begin
							vec_req_o  <= 1'b1;
							vec_kind_o <= lpm_pkg::VEC_WTMR;
						end
					end
					lpm_pkg::MODE_DEEP: vec_req_o <= 1'b0;
				endcase
			end
		end
	end

	// Cause of the last exit from a low-power mode, kept across the restart
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wake_src_q <= lpm_pkg::VEC_RESET;
		end else if (pin_rst_act) begin
			wake_src_q <= lpm_pkg::VEC_RESET;
		end else if (mode_q != lpm_pkg::MODE_RUN && mode_d == lpm_pkg::MODE_RUN) begin
			if (irq_act) begin
				wake_src_q <= lpm_pkg::VEC_IRQ;
			end else if (keypad_act && mode_q != lpm_pkg::MODE_DEEP) begin
				wake_src_q <= lpm_pkg::VEC_KEYPAD;
			end else if (wtmr_tick_q) begin
				wake_src_q <= lpm_pkg::VEC_WTMR;
			end else begin
				wake_src_q <= lpm_pkg::VEC_STACK;
			end
		end
	end

	// Debug gate: in low-power modes only halt and status commands are served
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dbg_ack_o    <= 1'b0;
			dbg_err_o    <= 1'b0;
			dbg_reject_o <= 1'b0;
			dbg_mem_go_o <= 1'b0;
		end else begin
			dbg_ack_o    <= 1'b0;
			dbg_err_o    <= 1'b0;
			dbg_reject_o <= 1'b0;
			dbg_mem_go_o <= 1'b0;
			if (dbg_valid_i) begin
				if (mode_q == lpm_pkg::MODE_RUN) begin
					dbg_ack_o    <= 1'b1;
					dbg_mem_go_o <= (dbg_cmd_i != lpm_pkg::DBG_CMD_HALT);
				end else if (dbg_cmd_i == lpm_pkg::DBG_CMD_HALT) begin
					dbg_ack_o <= 1'b1; // see RULE4
				end else if (dbg_cmd_i == lpm_pkg::DBG_CMD_MEM_STAT) begin
					dbg_ack_o <= 1'b1; // see RULE4
					dbg_err_o <= 1'b1;
				end else begin
					dbg_reject_o <= 1'b1; // see RULE4
				end
			end
		end
	end

	// 1 kHz source divided down from clk_i and periodic wakeup divider
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lpo_cnt_q   <= '0;
			wtmr_cnt_q  <= '0;
			wtmr_tick_q <= 1'b0;
			lpo_en_o    <= 1'b0;
		end else begin
			wtmr_tick_q <= 1'b0;
			lpo_en_o    <= lpo_en && !sys_clr;
			if (!lpo_en || sys_clr) begin
				lpo_cnt_q  <= '0; // see RULE14
				wtmr_cnt_q <= '0;
			end else if (lpo_cnt_q == LPO_LAST) begin
				lpo_cnt_q <= '0;
				if (wtmr_cnt_q >= wtmr_last(wake_sel)) begin
					wtmr_cnt_q  <= '0;
					wtmr_tick_q <= 1'b1; // see RULE14
				end else begin
					wtmr_cnt_q <= wtmr_cnt_q + lpm_pkg::WTMR_CNT_W'(1);
				end
			end else begin
				lpo_cnt_q <= lpo_cnt_q + lpm_pkg::LPO_CNT_W'(1);
			end
		end
	end

	// Avalon-MM slave: waitrequest drops for one cycle, one cycle after a request
	assign wr_go  = avs_write_i && !wait_q && avs_byteenable_i[0];
	assign ack_wr = wr_hit(avs_address_i, lpm_pkg::OFF_PWR_ACK, wr_go) &&
		avs_writedata_i[lpm_pkg::ACK_BIT];

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wait_q  <= 1'b1;
			rdata_q <= '0;
		end else begin
			if (wait_q && (avs_read_i || avs_write_i)) begin
				wait_q <= 1'b0;
			end else begin
				wait_q <= 1'b1;
			end
			if (wait_q && avs_read_i) begin
				rdata_q <= '0;
				unique case (avs_address_i)
					lpm_pkg::OFF_CTRL:      rdata_q[lpm_pkg::REG_W-1:0] <= ctrl_q;
					lpm_pkg::OFF_STATUS: begin
						rdata_q[lpm_pkg::STAT_MODE_LSB +: 2]  <= mode_q;
						rdata_q[lpm_pkg::STAT_PPD_BIT]        <= partial_powerdown_flag_q;
						rdata_q[lpm_pkg::STAT_LATCH_BIT]      <= latched_q;
						rdata_q[lpm_pkg::STAT_BKGD_BIT]       <= background_active_o;
						rdata_q[lpm_pkg::STAT_WAKE_LSB +: 3]  <= wake_src_q;
					end
					lpm_pkg::OFF_PORT_DATA: rdata_q[lpm_pkg::REG_W-1:0] <= port_data_q;
					lpm_pkg::OFF_PORT_DIR:  rdata_q[lpm_pkg::REG_W-1:0] <= port_dir_q;
					lpm_pkg::OFF_PERIPH_EN: rdata_q[lpm_pkg::REG_W-1:0] <= periph_en_q;
					lpm_pkg::OFF_OSC_TRIM:  rdata_q[lpm_pkg::REG_W-1:0] <= osc_trim_q;
					default:                rdata_q <= '0;
				endcase
			end
		end
	end
	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = wait_q;

	// Software registers return to reset values on any system restart
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q      <= lpm_pkg::CTRL_RST;
			port_data_q <= lpm_pkg::PORT_DATA_RST;
			port_dir_q  <= lpm_pkg::PORT_DIR_RST;
			periph_en_q <= lpm_pkg::PERIPH_EN_RST;
			osc_trim_q  <= lpm_pkg::OSC_TRIM_RST;
		end else if (sys_clr) begin
			ctrl_q      <= lpm_pkg::CTRL_RST; // see RULE10
			port_data_q <= lpm_pkg::PORT_DATA_RST; // see RULE12
			port_dir_q  <= lpm_pkg::PORT_DIR_RST;
			periph_en_q <= lpm_pkg::PERIPH_EN_RST; // see RULE13
			osc_trim_q  <= lpm_pkg::OSC_TRIM_RST;
		end else begin
			if (wr_hit(avs_address_i, lpm_pkg::OFF_CTRL, wr_go)) begin
				ctrl_q <= avs_writedata_i[lpm_pkg::REG_W-1:0];
			end
			if (wr_hit(avs_address_i, lpm_pkg::OFF_PORT_DATA, wr_go)) begin
				port_data_q <= avs_writedata_i[lpm_pkg::REG_W-1:0];
			end
			if (wr_hit(avs_address_i, lpm_pkg::OFF_PORT_DIR, wr_go)) begin
				port_dir_q <= avs_writedata_i[lpm_pkg::REG_W-1:0];
			end
			if (wr_hit(avs_address_i, lpm_pkg::OFF_PERIPH_EN, wr_go)) begin
				periph_en_q <= avs_writedata_i[lpm_pkg::REG_W-1:0];
			end
			// Trim is untouched by shallow stop so the loop relocks quickly
			if (wr_hit(avs_address_i, lpm_pkg::OFF_OSC_TRIM, wr_go)) begin
				osc_trim_q <= avs_writedata_i[lpm_pkg::REG_W-1:0]; // see RULE20
			end
		end
	end
	assign osc_trim_o = osc_trim_q;

	// Pad latch and powerdown flag survive the restart; only power-on or an acknowledge write clears them
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			latched_q                <= 1'b0;
			partial_powerdown_flag_q <= 1'b0;
		end else begin
			if (ack_wr) begin
				latched_q                <= 1'b0; // see RULE8
				partial_powerdown_flag_q <= 1'b0; // see RULE11
			end
			if (enter_deep) begin
				latched_q <= 1'b1; // see RULE8
			end
			if (deep_wake) begin
				partial_powerdown_flag_q <= 1'b1; // see RULE11
				latched_q                <= 1'b1; // see RULE10
			end
		end
	end

	// Shallow stop needs no latch: the registers feeding the pads are retained
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pad_out_o      <= '0;
			pad_oe_o       <= '0;
			pins_latched_o <= 1'b0;
		end else begin
			pins_latched_o <= latched_q || enter_deep;
			if (!latched_q && !enter_deep) begin
				for (int i = 0; i < lpm_pkg::PIN_W; i++) begin
					pad_out_o[i] <= periph_en_q[i] ? periph_out_i[i] : port_data_q[i]; // see RULE16
					pad_oe_o[i]  <= periph_en_q[i] ? periph_oe_i[i] : port_dir_q[i]; // see RULE13
				end
			end
		end
	end
endmodule // lpm_mode_ctrl
`default_nettype wire

// File: bench/lpm_mode_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_mode_ctrl_checker (
	input wire logic                      clk_i, rst_n_i, wait_exec_i, irq_req_i, irq_pin_i,
	input wire logic                      dbg_valid_i, cpu_clk_en_o, cond_code_mask_clr_o,
	input wire logic                      vec_req_o, sys_reset_o, background_active_o,
	input wire logic                      dbg_ack_o, dbg_err_o, dbg_reject_o, dbg_mem_go_o,
	input wire logic                      core_power_off_o, regulator_standby_o, osc_halt_o,
	input wire logic                      converter_standby_o, converter_disable_o, gen_off_o,
	input wire logic                      gen_clk_static_o, pins_latched_o, lpo_en_o,
	input wire logic [1:0]                dbg_cmd_i, mode_o,
	input wire logic [2:0]                vec_kind_o,
	input wire logic [lpm_pkg::PIN_W-1:0] pad_out_o, pad_oe_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Start on the falling edge only, so a long low does not demand a second restart
	sequence s_irq_low;
		mode_o == 2'h3 && $fell(irq_pin_i) ##1 !irq_pin_i ##1 !irq_pin_i;
	endsequence
	a_wait_entry: assert property (mode_o == 2'h0 && wait_exec_i
		|=> mode_o == 2'h1 && !cpu_clk_en_o && cond_code_mask_clr_o) else $error("wait entry");
	a_wait_exit: assert property (mode_o == 2'h1 && irq_req_i && !dbg_valid_i
		|=> mode_o == 2'h0 && vec_req_o && vec_kind_o == 3'h1) else $error("wait exit");
	a_dbg_status: assert property (mode_o != 2'h0 && dbg_valid_i && dbg_cmd_i == 2'h1
		|=> dbg_ack_o && dbg_err_o && !dbg_mem_go_o) else $error("status cmd");
	a_dbg_reject: assert property (mode_o != 2'h0 && dbg_valid_i && dbg_cmd_i[1]
		|=> dbg_reject_o && !dbg_ack_o) else $error("cmd not refused");
	a_dbg_halt: assert property (mode_o == 2'h1 && dbg_valid_i && dbg_cmd_i == 2'h0
		|=> mode_o == 2'h0 && background_active_o && !vec_req_o) else $error("halt wake");
	a_deep_power: assert property (mode_o == 2'h3
		|-> core_power_off_o && regulator_standby_o && converter_standby_o) else $error("deep pwr");
	a_shallow_power: assert property (mode_o == 2'h2
		|-> converter_disable_o && gen_off_o && gen_clk_static_o && osc_halt_o
		&& regulator_standby_o) else $error("shallow pwr");
	a_latch_hold: assert property (pins_latched_o && $past(pins_latched_o)
		|-> $stable(pad_out_o) && $stable(pad_oe_o)) else $error("pads moved");
	a_deep_wake: assert property (s_irq_low
		|-> ##[0:4] (sys_reset_o && pins_latched_o)) else $error("deep wake");
	a_timer_gate: assert property (vec_req_o && vec_kind_o == 3'h4
		|-> lpo_en_o) else $error("timer off");
endmodule // lpm_mode_ctrl_checker
bind lpm_mode_ctrl lpm_mode_ctrl_checker i_lpm_mode_ctrl_checker (.*);
`default_nettype wire

// File: bench/lpm_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Raises only the interrupt request while in wait; wait and stop pulses come from the testbench
module lpm_core_model #(
	parameter int unsigned DELAY = 3
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       vec_req_i,
	input  wire logic       go_i,
	output logic            irq_req_o
);
	int unsigned cnt_q;
	// Pending request stays a level until its vector is fetched
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q     <= 0;
			irq_req_o <= 1'b0;
		end else if (vec_req_i) begin
			cnt_q     <= 0;
			irq_req_o <= 1'b0;
		end else if (go_i && mode_i == 2'h1) begin
			cnt_q     <= cnt_q + 1;
			irq_req_o <= cnt_q >= DELAY;
		end
	end
endmodule // lpm_core_model
`default_nettype wire

// File: bench/lpm_mode_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lpm_mode_ctrl_tb;
	logic clk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0, reset_pin_n_i = 1, go = 0;
	logic irq_pin_i = 1, irq_req_i, wait_exec_i = 0, stop_exec_i = 0, dbg_valid_i = 0;
	logic background_mode_select_pin_i = 1, pins_latched_o, cpu_clk_en_o, vec_req_o, lpo_en_o;
	logic [4:0] avs_address_i = 0;
	logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
	logic [3:0] avs_byteenable_i = 4'hF;
	logic [7:0] keypad_pins_i = 0, periph_out_i = 0, periph_oe_i = 0, pad_out_o, pad_oe_o;
	logic [7:0] osc_trim_o;
	logic [1:0] dbg_cmd_i = 0, mode_o;
	logic [2:0] vec_kind_o;
	logic avs_waitrequest_o, cond_code_mask_clr_o, sys_reset_o, background_active_o, dbg_ack_o;
	logic dbg_err_o, dbg_reject_o, dbg_mem_go_o, core_power_off_o, regulator_standby_o;
	logic converter_standby_o, converter_disable_o, gen_off_o, gen_clk_static_o, osc_halt_o;
	int failures = 0, n_checks = 0;
	always #50 clk_i = ~clk_i;
	lpm_mode_ctrl #(.LPO_CYCLES(4)) i_lpm_mode_ctrl (.*);
	lpm_core_model i_lpm_core_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .mode_i(mode_o),
		.vec_req_i(vec_req_o), .go_i(go), .irq_req_o(irq_req_i));
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wt(input int n);
		if (n >= 400) begin
			failures++;
			finish_test();
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_address_i <= a;
		avs_writedata_i <= d;
		do begin @(posedge clk_i); n++; end while (avs_waitrequest_o !== 1'b0 && n < 400);
		wt(n);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		repeat (2) @(negedge clk_i);
	endtask
	task automatic wvec(input logic [2:0] k, input logic [7:0] kp = 8'h0, logic ip = 1'b1);
		int n = 0;
		@(posedge clk_i);
		{keypad_pins_i, irq_pin_i} <= {kp, ip};
		while (vec_req_o !== 1'b1 && n < 400) begin @(negedge clk_i); n++; end
		wt(n);
		chk(vec_kind_o, k, "vector kind");
		@(posedge clk_i);
		{keypad_pins_i, irq_pin_i} <= 9'h001;
		@(negedge clk_i);
	endtask
	task automatic exec(input logic s, input logic v, input logic [1:0] c);
		@(posedge clk_i);
		stop_exec_i <= s;
		wait_exec_i <= !s && !v;
		dbg_valid_i <= v;
		dbg_cmd_i <= c;
		@(posedge clk_i);
		{stop_exec_i, wait_exec_i, dbg_valid_i} <= 3'h0;
		@(negedge clk_i);
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		wvec(3'h0);
		bus(1'b0, lpm_pkg::OFF_OSC_TRIM, 32'h0);
		chk(q, 32'h80, "trim reset");
		bus(1'b0, 5'h1C, 32'h0);
		chk(q, 32'h0, "unmapped read");
		$display("boot done");
		exec(1'b0, 1'b0, 2'h0);
		chk({mode_o, cpu_clk_en_o, cond_code_mask_clr_o}, 4'h5, "wait entry");
		exec(1'b0, 1'b1, 2'h1);
		chk({dbg_ack_o, dbg_err_o, dbg_mem_go_o}, 3'h6, "status cmd");
		exec(1'b0, 1'b1, 2'h2);
		chk(dbg_reject_o, 1'b1, "other cmd");
		go <= 1'b1;
		wvec(3'h1);
		go <= 1'b0;
		exec(1'b0, 1'b0, 2'h0);
		exec(1'b0, 1'b1, 2'h0);
		chk({mode_o, background_active_o, vec_req_o}, 4'h2, "halt in wait");
		$display("wait done");
		bus(1'b1, lpm_pkg::OFF_OSC_TRIM, 32'h5A);
		bus(1'b1, lpm_pkg::OFF_CTRL, 32'h38);
		exec(1'b1, 1'b0, 2'h0);
		chk(mode_o, 2'h2, "deep refused");
		chk({converter_disable_o, gen_clk_static_o, osc_halt_o}, 3'h7, "shallow");
		wvec(3'h3, 8'h04);
		chk(osc_trim_o, 8'h5A, "trim kept");
		bus(1'b1, lpm_pkg::OFF_CTRL, 32'h01);
		chk(lpo_en_o, 1'b1, "lpo on");
		exec(1'b1, 1'b0, 2'h0);
		wvec(3'h4);
		bus(1'b1, lpm_pkg::OFF_CTRL, 32'h0);
		chk(lpo_en_o, 1'b0, "lpo off");
		$display("shallow done");
		bus(1'b1, lpm_pkg::OFF_PORT_DATA, 32'hA5);
		bus(1'b1, lpm_pkg::OFF_PORT_DIR, 32'hFF);
		bus(1'b1, lpm_pkg::OFF_CTRL, 32'h08);
		exec(1'b1, 1'b0, 2'h0);
		chk({mode_o, pins_latched_o, core_power_off_o}, 4'hF, "deep entry");
		wvec(3'h0, 8'h00, 1'b0);
		chk({pad_out_o, pad_oe_o}, 16'hA5FF, "pads held");
		bus(1'b0, lpm_pkg::OFF_STATUS, 32'h0);
		chk(q[3:2], 2'h3, "flag and latch");
		bus(1'b1, lpm_pkg::OFF_PWR_ACK, 32'h1);
		chk({pins_latched_o, pad_out_o, pad_oe_o}, 17'h0, "latch open");
		$display("deep done");
		finish_test();
	end
endmodule // lpm_mode_ctrl_tb
`default_nettype wire
